/* pwu_pkg.sv */
/*
 pwu_pkg: constants, register map, field layout and carrier types of the pwm waveform unit.
 assumes one 125 MHz clock and an AHB-Lite register bus with 32-bit single word transfers.
*/
//
// Contract
// - dma sync event pulses exactly when the interrupt would pulse.
// - leaving power-down keeps registers but idles; a new start write resumes.
// - edge trigger configured before power-down needs a fresh edge after restart.
// - run-through-halt set: waveform continues during debug suspend.
// - run-through-halt clear: suspend freezes output, counters and interrupts; an untriggered start write still opens a period at first-phase level.
// - edges seen during suspend while waiting are kept; period starts on release.
// - seven word registers decoded at offsets 00h to 18h.
// - identity register read-only with scheme, function and revision fields.
// - configuration bit 17 reads running state.
// - configuration bit 16 reads present output level.
// - configuration bit 6 gates the interrupt.
// - configuration bit 5 selects the inactive level.
// - configuration bit 4 selects first phase level; second phase opposite.
// - bits 3-2 select trigger: none, rising, falling, reserved.
// - bits 1-0 select mode: disabled, one-shot, continuous, reserved.
// - a period lasts period value plus one cycles.
// - first phase lasts the first-phase length in cycles.
// - one-shot runs repeat count plus one periods, then idles and interrupts.
// - continuous mode copies shadows at each period start, then interrupts.
package pwu_pkg;
	localparam logic [7:0] PWU_OFS_IDENT = 8'h00;
	localparam logic [7:0] PWU_OFS_SUSP  = 8'h04;
	localparam logic [7:0] PWU_OFS_CFG   = 8'h08;
	localparam logic [7:0] PWU_OFS_START = 8'h0C;
	localparam logic [7:0] PWU_OFS_RPT   = 8'h10;
	localparam logic [7:0] PWU_OFS_PER   = 8'h14;
	localparam logic [7:0] PWU_OFS_PH1   = 8'h18;
	// identity values are arbitrary, not any real part's
	localparam logic [1:0]  PWU_ID_SCHEME   = 2'h2;
	localparam logic [11:0] PWU_ID_FUNCTION = 12'h5A5;
	localparam logic [4:0]  PWU_ID_LOGICREV = 5'h03;
	localparam logic [2:0]  PWU_ID_MAJOR    = 3'h2;
	localparam logic [1:0]  PWU_ID_CUSTOM   = 2'h0;
	localparam logic [5:0]  PWU_ID_MINOR    = 6'h01;
	localparam int PWU_BIT_OPSTATE = 17;
	localparam int PWU_BIT_LEVEL   = 16;
	localparam int PWU_BIT_IRQ     = 6;
	localparam int PWU_BIT_IDLE    = 5;
	localparam int PWU_BIT_PH1     = 4;
	localparam int PWU_BIT_TRIG    = 2;
	localparam int PWU_BIT_MODE    = 0;
	localparam int PWU_BIT_FREE    = 0;
	localparam logic [1:0] PWU_MODE_OFF  = 2'h0;
	localparam logic [1:0] PWU_MODE_ONE  = 2'h1;
	localparam logic [1:0] PWU_MODE_CONT = 2'h2;
	localparam logic [1:0] PWU_TRIG_NONE = 2'h0;
	localparam logic [1:0] PWU_TRIG_RISE = 2'h1;
	localparam logic [1:0] PWU_TRIG_FALL = 2'h2;
	localparam logic [31:0] PWU_RST_WORD = 32'h0000_0000;
	localparam logic [1:0]  PWU_HTRANS_NONSEQ = 2'h2;

	typedef enum {PWU_IDLE, PWU_ARMED, PWU_RUN} pwu_state_t;

	typedef struct packed {
		logic       irq_allow;
		logic       idle_level;
		logic       phase_one_level;
		logic [1:0] trigger_edge_select;
		logic [1:0] mode;
	} pwu_cfg_t;

	typedef struct packed {
		logic        sel;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] haddr;
	} pwu_ahb_req_t;
endpackage

/* pwu_top.sv */
/*
 pwu_top: one pwm channel with its AHB-Lite register bank.
 assumes a synchronous active-high reset, one clock, an asynchronous trigger pin,
 and a power controller that pulses power_wake when the block leaves power-down.
*/
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module pwu_top
	import pwu_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// system
	input  wire logic        debug_suspend,
	input  wire logic        power_wake,
	input  wire logic        video_sync_input,
	// outputs
	output logic             pwm_out,
	output logic             irq,
	output logic             dma_sync_event
);
	pwu_ahb_req_t req_reg;
	pwu_cfg_t     cfg_reg;
	logic         free_reg;
	logic [7:0]   rpt_reg;
	logic [31:0]  per_reg;
	logic [31:0]  ph1_reg;
	pwu_state_t   state_reg;
	pwu_state_t   state_next;
	logic [31:0]  cnt_reg;
	logic [31:0]  sh_per_reg;
	logic [31:0]  sh_ph1_reg;
	logic [7:0]   left_reg;
	logic         level_reg;
	logic         level_next;
	logic         event_reg;
	logic         seen_reg;
	logic [2:0]   sync_reg;
	logic [31:0]  rdata_next;
	logic         pin_reg;
	logic [31:0]  gap_reg;

	// bus decode
	wire addr_phase = hsel && hready && htrans == PWU_HTRANS_NONSEQ;
	wire wr_do      = req_reg.sel && req_reg.hwrite;
	wire [7:0] wofs = req_reg.haddr[7:0];
	wire wr_susp    = wr_do && wofs == PWU_OFS_SUSP;
	wire wr_cfg     = wr_do && wofs == PWU_OFS_CFG;
	wire wr_start   = wr_do && wofs == PWU_OFS_START && hwdata[0];
	wire wr_rpt     = wr_do && wofs == PWU_OFS_RPT;
	wire wr_per     = wr_do && wofs == PWU_OFS_PER;
	wire wr_ph1     = wr_do && wofs == PWU_OFS_PH1;
	wire [7:0] rofs = haddr[7:0];
	wire [31:0] ident_word = {PWU_ID_SCHEME, 2'h0, PWU_ID_FUNCTION, PWU_ID_LOGICREV,
		PWU_ID_MAJOR, PWU_ID_CUSTOM, PWU_ID_MINOR};
	wire running = state_reg != PWU_IDLE;
	wire [31:0] cfg_word = {14'h0, running, level_reg, 9'h0, cfg_reg};

	// read mux, unmapped and write-only addresses read zero
	always_comb
	begin
		if (rofs == PWU_OFS_IDENT)
			rdata_next = ident_word;
		else if (rofs == PWU_OFS_SUSP)
			rdata_next = {31'h0, free_reg};
		else if (rofs == PWU_OFS_CFG)
			rdata_next = cfg_word;
		else if (rofs == PWU_OFS_RPT)
			rdata_next = {24'h0, rpt_reg};
		else if (rofs == PWU_OFS_PER)
			rdata_next = per_reg;
		else if (rofs == PWU_OFS_PH1)
			rdata_next = ph1_reg;
		else
			rdata_next = PWU_RST_WORD;
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			req_reg <= '0;
			hrdata  <= PWU_RST_WORD;
		end
		else if (hready)
		begin
			req_reg <= '{addr_phase, htrans, hwrite, hsize, haddr};
			if (addr_phase && !hwrite)
				hrdata <= rdata_next;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cfg_reg  <= '0;
			free_reg <= 1'b0;
			rpt_reg  <= 8'h00;
			per_reg  <= PWU_RST_WORD;
			ph1_reg  <= PWU_RST_WORD;
		end
		else
		begin
			if (wr_cfg)
				cfg_reg <= pwu_cfg_t'(hwdata[6:0]);
			if (wr_susp)
				free_reg <= hwdata[PWU_BIT_FREE];
			if (wr_rpt)
				rpt_reg <= hwdata[7:0];
			if (wr_per)
				per_reg <= hwdata;
			if (wr_ph1)
				ph1_reg <= hwdata;
		end
	end

	// trigger pin: three flops, change counts when stages two and three agree
	// pin_reg is the accepted level; a glitch seen by one stage only never counts
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sync_reg <= 3'h0;
			pin_reg  <= 1'b0;
		end
		else
		begin
			sync_reg <= {sync_reg[1:0], video_sync_input};
			if (sync_reg[1] == sync_reg[2])
				pin_reg <= sync_reg[2];
		end
	end
	wire edge_rise = sync_reg[1] && sync_reg[2] && !pin_reg;
	wire edge_fall = !sync_reg[1] && !sync_reg[2] && pin_reg;
	wire edge_hit  = (cfg_reg.trigger_edge_select == PWU_TRIG_RISE && edge_rise) ||
		(cfg_reg.trigger_edge_select == PWU_TRIG_FALL && edge_fall);

	// halt gating: freeze only when run-through-halt is clear
	wire frozen   = debug_suspend && !free_reg;
	wire mode_off = cfg_reg.mode == PWU_MODE_OFF || cfg_reg.mode == 2'h3;
	wire trig_on  = cfg_reg.trigger_edge_select == PWU_TRIG_RISE ||
		cfg_reg.trigger_edge_select == PWU_TRIG_FALL;
	wire go_now   = state_reg == PWU_ARMED && (edge_hit || seen_reg) && !frozen;
	wire per_end  = state_reg == PWU_RUN && !frozen && cnt_reg == sh_per_reg;
	wire last_per = cfg_reg.mode == PWU_MODE_ONE && left_reg == 8'h00;
	// untriggered start loads shadows and opens the first period at once
	wire start_go = state_reg == PWU_IDLE && wr_start && !mode_off && !trig_on &&
		!power_wake;
	wire load     = go_now || start_go || (per_end && !last_per);
	wire done     = per_end && last_per;
	wire fire     = cfg_reg.irq_allow && !frozen &&
		(done || (load && cfg_reg.mode == PWU_MODE_CONT));

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			PWU_IDLE:
				if (wr_start && !mode_off)
					state_next = trig_on ? PWU_ARMED : PWU_RUN;
			PWU_ARMED:
				if (go_now)
					state_next = PWU_RUN;
			PWU_RUN:
				if (done)
					state_next = PWU_IDLE;
			default:
				state_next = PWU_IDLE;
		endcase
		if (mode_off || power_wake)
			state_next = PWU_IDLE;
	end

	// output level: phase one until count reaches its length
	always_comb
	begin
		level_next = level_reg;
		if (state_next != PWU_RUN)
			level_next = cfg_reg.idle_level;
		else if (load)
			level_next = (ph1_reg != PWU_RST_WORD) ? cfg_reg.phase_one_level
				: !cfg_reg.phase_one_level;
		else if (!frozen)
			level_next = (cnt_reg + 32'h1 < sh_ph1_reg) ? cfg_reg.phase_one_level
				: !cfg_reg.phase_one_level;
		if (frozen && state_reg == PWU_RUN && state_next == PWU_RUN)
			level_next = level_reg;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_reg  <= PWU_IDLE;
			cnt_reg    <= PWU_RST_WORD;
			sh_per_reg <= PWU_RST_WORD;
			sh_ph1_reg <= PWU_RST_WORD;
			left_reg   <= 8'h00;
			level_reg  <= 1'b0;
			event_reg  <= 1'b0;
			seen_reg   <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			level_reg <= level_next;
			event_reg <= fire;
			// edges kept only while armed and frozen
			seen_reg  <= state_next == PWU_ARMED && (seen_reg || (edge_hit && frozen));
			if (load)
			begin
				cnt_reg    <= PWU_RST_WORD;
				sh_per_reg <= per_reg;
				sh_ph1_reg <= ph1_reg;
				// continuous reloads keep the count fresh for a later switch to one-shot
				left_reg   <= (state_reg != PWU_RUN || cfg_reg.mode == PWU_MODE_CONT) ?
					rpt_reg : left_reg - 8'h01;
			end
			else if (state_reg == PWU_RUN && !frozen)
				cnt_reg <= cnt_reg + 32'h1;
		end
	end

	assign pwm_out        = level_reg;
	assign irq            = event_reg;
	assign dma_sync_event = event_reg;

	// checker helper: cycles since this period began, counted apart from cnt_reg
	always_ff @(posedge clock)
	begin
		if (sys_rst || state_reg != PWU_RUN || per_end)
			gap_reg <= PWU_RST_WORD;
		else if (!frozen)
			gap_reg <= gap_reg + 32'h1;
	end

	// bus side
	a_hrdata_stands: assert property (@(posedge clock) disable iff (sys_rst)
		!(hsel && hready && htrans == PWU_HTRANS_NONSEQ && !hwrite)
		|=> $stable(hrdata))
		else $error("read data changed without a read");
	a_ident_reads: assert property (@(posedge clock) disable iff (sys_rst)
		req_reg.sel && !req_reg.hwrite && req_reg.haddr[7:0] == PWU_OFS_IDENT
		|-> hrdata == ident_word)
		else $error("identity word wrong");
	a_cfg_reserved: assert property (@(posedge clock) disable iff (sys_rst)
		req_reg.sel && !req_reg.hwrite && req_reg.haddr[7:0] == PWU_OFS_CFG
		|-> hrdata[31:18] == 14'h0 && hrdata[15:7] == 9'h0)
		else $error("config reserved bits set");
	a_status_reads: assert property (@(posedge clock) disable iff (sys_rst)
		req_reg.sel && !req_reg.hwrite && req_reg.haddr[7:0] == PWU_OFS_CFG
		|-> hrdata[17] == $past(running) && hrdata[16] == $past(pwm_out))
		else $error("status bits read wrong");
	a_susp_reserved: assert property (@(posedge clock) disable iff (sys_rst)
		req_reg.sel && !req_reg.hwrite && req_reg.haddr[7:0] == PWU_OFS_SUSP
		|-> hrdata[31:1] == 31'h0)
		else $error("suspend reserved bits set");
	a_start_reads_zero: assert property (@(posedge clock) disable iff (sys_rst)
		req_reg.sel && !req_reg.hwrite && req_reg.haddr[7:0] == PWU_OFS_START
		|-> hrdata == PWU_RST_WORD)
		else $error("start register not zero");
	a_cfg_bits_read: assert property (@(posedge clock) disable iff (sys_rst)
		1'b1
		|-> cfg_word[17:16] == {running, pwm_out})
		else $error("status bits wrong");

	// events and power
	a_sync_equals_irq: assert property (@(posedge clock) disable iff (sys_rst)
		1'b1
		|-> dma_sync_event == irq)
		else $error("dma event differs from irq");
	a_irq_cause: assert property (@(posedge clock) disable iff (sys_rst)
		irq
		|-> $past(done) || $past(load))
		else $error("irq without a cause");
	a_irq_gated: assert property (@(posedge clock) disable iff (sys_rst)
		irq
		|-> $past(cfg_reg.irq_allow))
		else $error("irq while disabled");
	a_wake_idles: assert property (@(posedge clock) disable iff (sys_rst)
		power_wake
		|=> !running)
		else $error("not idle after wake");

	// waveform
	a_start_runs: assert property (@(posedge clock) disable iff (sys_rst)
		start_go
		|=> state_reg == PWU_RUN && cnt_reg == PWU_RST_WORD)
		else $error("start did not run");
	a_start_ignored: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == PWU_RUN && wr_start && !done && !mode_off && !power_wake
		|=> state_reg == PWU_RUN)
		else $error("start disturbed a run");
	a_shadow_copy: assert property (@(posedge clock) disable iff (sys_rst)
		load
		|=> sh_per_reg == $past(per_reg) && sh_ph1_reg == $past(ph1_reg))
		else $error("shadows not copied");
	a_cnt_bounded: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == PWU_RUN
		|-> cnt_reg <= sh_per_reg)
		else $error("count beyond period");
	a_per_length: assert property (@(posedge clock) disable iff (sys_rst)
		per_end
		|-> gap_reg == sh_per_reg)
		else $error("period length wrong");
	a_phase_level: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == PWU_RUN && $stable(cfg_reg)
		|-> pwm_out == ((cnt_reg < sh_ph1_reg) ? cfg_reg.phase_one_level : !cfg_reg.phase_one_level))
		else $error("phase level wrong");
	a_oneshot_ends: assert property (@(posedge clock) disable iff (sys_rst)
		done
		|=> state_reg == PWU_IDLE)
		else $error("one-shot did not stop");
	a_oneshot_irq: assert property (@(posedge clock) disable iff (sys_rst)
		done && cfg_reg.irq_allow
		|=> irq)
		else $error("one-shot end irq missing");
	a_cont_irq: assert property (@(posedge clock) disable iff (sys_rst)
		load && !frozen && cfg_reg.irq_allow && cfg_reg.mode == PWU_MODE_CONT
		|=> irq)
		else $error("period start irq missing");
	a_idle_level: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg != PWU_RUN
		|-> pwm_out == $past(cfg_reg.idle_level))
		else $error("idle level wrong");
	a_mode_off_stops: assert property (@(posedge clock) disable iff (sys_rst)
		mode_off
		|=> state_reg == PWU_IDLE)
		else $error("disable ignored");
	a_off_level: assert property (@(posedge clock) disable iff (sys_rst)
		mode_off
		|=> pwm_out == $past(cfg_reg.idle_level))
		else $error("disable left wrong level");

	// trigger and halt
	a_trig_waits: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == PWU_IDLE && wr_start && trig_on && !mode_off && !power_wake
		|=> state_reg == PWU_ARMED)
		else $error("trigger not armed");
	a_armed_waits: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == PWU_ARMED && !edge_hit && !seen_reg && !mode_off && !power_wake
		|=> state_reg == PWU_ARMED)
		else $error("started without an edge");
	a_edge_kept: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == PWU_ARMED && edge_hit && frozen && !mode_off && !power_wake
		|=> seen_reg)
		else $error("edge in halt lost");
	a_kept_starts: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == PWU_ARMED && seen_reg && !frozen && !mode_off && !power_wake
		|=> state_reg == PWU_RUN)
		else $error("kept edge did not start");
	a_free_runs: assert property (@(posedge clock) disable iff (sys_rst)
		state_reg == PWU_RUN && free_reg && !mode_off && !power_wake && !per_end
		|=> cnt_reg == $past(cnt_reg) + 32'h1)
		else $error("count stalled when free");
	a_halt_freezes: assert property (@(posedge clock) disable iff (sys_rst)
		frozen && state_reg == PWU_RUN && !mode_off && !power_wake
		|=> $stable(cnt_reg) && $stable(pwm_out) && !irq)
		else $error("halt no freeze");
	a_halt_no_irq: assert property (@(posedge clock) disable iff (sys_rst)
		frozen
		|=> !irq)
		else $error("irq during halt");
	c_oneshot_done: cover property (@(posedge clock) disable iff (sys_rst)
		done && cfg_reg.mode == PWU_MODE_ONE);
	c_cont_reload: cover property (@(posedge clock) disable iff (sys_rst)
		per_end && cfg_reg.mode == PWU_MODE_CONT);
	c_trig_start: cover property (@(posedge clock) disable iff (sys_rst) go_now);
	c_edge_in_halt: cover property (@(posedge clock) disable iff (sys_rst)
		seen_reg ##1 go_now);
endmodule

/* pwu_host_model.sv */
/*
 pwu_host_model: ahb-lite master standing in for the processor or dma engine.
 assumes one zero-or-more wait slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module pwu_host_model
	import pwu_pkg::*;
(
	// clock
	input  wire logic         clock,
	// ahb-lite master side
	output pwu_ahb_req_t      req,
	output logic       [31:0] hwdata,
	input  wire logic         hready,
	input  wire logic  [31:0] hrdata
);
	initial
	begin
		req = '0;
		hwdata = 32'h0;
	end

	// whole-word single transfer; waits on hready, never on a fixed count
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		// launch only just after a rising edge, whatever edge the caller stands on
		@(posedge clock);
		req <= '{1'h1, PWU_HTRANS_NONSEQ, w, 3'h2, {24'h0, a}};
		@(posedge clock);
		while (hready !== 1'h1)
			@(posedge clock);
		req <= '{1'h0, 2'h0, w, 3'h2, {24'h0, a}};
		// reads leave a toggled pattern, not stale data, on the write bus
		hwdata <= w ? d : ~hwdata;
		@(posedge clock);
		while (hready !== 1'h1)
			@(posedge clock);
		q = hrdata;
	endtask
endmodule

/* pwm_waveform_unit_test.sv */
/*
 pwm_waveform_unit_test: self-checking bench, counting model of the waveform.
 assumes pwu_host_model as the only bus master and hreadyout fed back as hready.
*/
`timescale 1ns/1ps
module pwm_waveform_unit_test
	import pwu_pkg::*;
;
	localparam logic [31:0] ID_WORD = {PWU_ID_SCHEME, 2'h0, PWU_ID_FUNCTION,
		PWU_ID_LOGICREV, PWU_ID_MAJOR, PWU_ID_CUSTOM, PWU_ID_MINOR};
	logic         clock, sys_rst, debug_suspend, power_wake, video_sync_input;
	logic         hreadyout, hresp, pwm_out, irq, dma_sync_event;
	logic  [31:0] hwdata, hrdata, q;
	logic  [31:0] ones_exp [8];
	pwu_ahb_req_t req;
	int           failures, compares, seed, period_length, ph1, i, m, n, t, w;

	pwu_host_model u_pwu_host_model (.clock(clock), .req(req), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata));
	pwu_top u_pwu_top (.clock(clock), .sys_rst(sys_rst), .hsel(req.sel), .haddr(req.haddr),
		.htrans(req.htrans), .hwrite(req.hwrite), .hsize(req.hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.debug_suspend(debug_suspend), .power_wake(power_wake),
		.video_sync_input(video_sync_input), .pwm_out(pwm_out), .irq(irq),
		.dma_sync_event(dma_sync_event));

	always #4 clock = ~clock;

	task stop_test;
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		u_pwu_host_model.xfer(1'h1, a, d, q);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		u_pwu_host_model.xfer(1'h0, a, 32'h0, q);
		chk("hrdata", e, q);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// bounded wait for a period start (irq) or for the output to rise
	task wait_on(input logic for_out);
		int c;
		@(negedge clock);
		for (c = 0; c < 300 && (for_out ? pwm_out !== 1'h1 : irq !== 1'h1); c++)
			@(negedge clock);
		chk("wait", 32'h0, 32'(c == 300));
	endtask

	// model: np periods of per+1 cycles, first ph1 cycles at lvl
	task wave(input int np, input logic lvl, input logic ir);
		int c;
		for (c = 0; c < np * (period_length + 1); c++)
		begin
			chk("pwm_out", (c % (period_length + 1) < ph1) ? lvl : !lvl, pwm_out);
			chk("irq", ir && c % (period_length + 1) == 0, irq);
			chk("dma_sync_event", ir && c % (period_length + 1) == 0, dma_sync_event);
			@(negedge clock);
		end
	endtask

	initial
	begin
		#400000;
		failures++;
		stop_test;
	end

	initial
	begin
		seed = 32'h96f236be;
		{failures, compares} = 0;
		{clock, debug_suspend, power_wake, video_sync_input} = 4'h0;
		sys_rst = 1'h1;
		ones_exp = '{ID_WORD, 32'h1, 32'h1007F, 32'h0, 32'hFF, '1, '1, 32'h0};
		repeat (2) @(posedge clock);
		sys_rst <= 1'h0;
		for (i = 0; i < 8; i++) rd(8'(i * 4), i == 0 ? ID_WORD : 32'h0);
		for (i = 0; i < 8; i++) wr(8'(i * 4), 32'hFFFFFFFF);
		for (i = 0; i < 8; i++) rd(8'(i * 4), ones_exp[i]);
		wr(PWU_OFS_SUSP, 32'h0);
		for (i = 0; i < 3; i++)
		begin
			period_length = 8 + {$random(seed)} % 8;
			ph1 = {$random(seed)} % (period_length + 2);
			wr(PWU_OFS_PER, period_length);
			wr(PWU_OFS_PH1, ph1);
			wr(PWU_OFS_CFG, 32'h42 | (i % 2) << 4);
			wr(PWU_OFS_START, 32'h1);
			wait_on(1'h0);
			wave(3, 1'(i % 2), 1'h1);
			wr(PWU_OFS_CFG, 32'h20);
			repeat (2) @(negedge clock);
			chk("idle level", 32'h1, pwm_out);
			rd(PWU_OFS_CFG, 32'h10020);
		end
		for (i = 0; i < 2; i++)
		begin
			period_length = 3 + {$random(seed)} % 6;
			ph1 = 2;
			m = {$random(seed)} % 4;
			wr(PWU_OFS_RPT, m);
			wr(PWU_OFS_PER, period_length);
			wr(PWU_OFS_PH1, ph1);
			wr(PWU_OFS_CFG, i ? 32'h51 : 32'h11);
			wr(PWU_OFS_START, 32'h1);
			wait_on(1'h1);
			wave(m + 1, 1'h1, 1'h0);
			n = 0;
			repeat (3)
			begin
				chk("pwm_out", 32'h0, pwm_out);
				n = n + (irq === 1'h1) + (dma_sync_event === 1'h1);
				@(negedge clock);
			end
			chk("irq count", 2 * i, n);
			rd(PWU_OFS_CFG, i ? 32'h51 : 32'h11);
		end
		period_length = 8;
		ph1 = 3;
		wr(PWU_OFS_PER, period_length);
		wr(PWU_OFS_PH1, ph1);
		for (t = 1; t < 3; t++)
		begin
			wr(PWU_OFS_CFG, 32'h0);
			@(posedge clock) video_sync_input <= (t == 2);
			wr(PWU_OFS_CFG, 32'h52 | t << 2);
			for (w = 0; w < 2; w++)
			begin
				wr(PWU_OFS_START, 32'h1);
				repeat (12) @(negedge clock);
				chk("armed", 32'h0, pwm_out);
				@(posedge clock) video_sync_input <= (t == 1);
				wait_on(1'h0);
				wave(1, 1'h1, 1'h1);
				if (w == 0)
				begin
					@(posedge clock) power_wake <= 1'h1;
					@(posedge clock) power_wake <= 1'h0;
					rd(PWU_OFS_CFG, 32'h52 | t << 2);
					rd(PWU_OFS_PER, period_length);
					@(posedge clock) video_sync_input <= (t == 2);
				end
			end
		end
		wr(PWU_OFS_CFG, 32'h52);
		wr(PWU_OFS_START, 32'h1);
		wait_on(1'h0);
		@(posedge clock) debug_suspend <= 1'h1;
		repeat (8)
		begin
			@(negedge clock);
			chk("frozen", 32'h1, pwm_out);
			chk("irq", 32'h0, irq);
		end
		@(posedge clock) debug_suspend <= 1'h0;
		wait_on(1'h0);
		wave(1, 1'h1, 1'h1);
		wr(PWU_OFS_SUSP, 32'h1);
		@(posedge clock) debug_suspend <= 1'h1;
		wait_on(1'h0);
		wave(2, 1'h1, 1'h1);
		wr(PWU_OFS_SUSP, 32'h0);
		wr(PWU_OFS_CFG, 32'h0);
		wr(PWU_OFS_CFG, 32'h56);
		wr(PWU_OFS_START, 32'h1);
		@(posedge clock) video_sync_input <= 1'h1;
		repeat (12) @(negedge clock);
		chk("held", 32'h0, pwm_out);
		@(posedge clock) debug_suspend <= 1'h0;
		wait_on(1'h0);
		wave(1, 1'h1, 1'h1);
		stop_test;
	end
endmodule
